// [inc/cct_pkg.sv]
// Purpose: Shared constants for the capture/compare timer control block
// Assumes: 32-bit register port, byte addresses
// Notes:   Field positions are bit indices of the control word

// ******************************************
// Package
// ******************************************
package cct_pkg;
  localparam int          DATA_W     = 32;
  localparam int          ADDR_W     = 8;
  localparam int          PRE_W      = 7;
  localparam int          SEL_W      = 3;
  localparam int          NUM_CH     = 2;
  // Register byte offsets
  localparam logic [7:0]  OFF_CTRL   = 8'h00;
  localparam logic [7:0]  OFF_COUNT  = 8'h0c;
  localparam logic [7:0]  OFF_CMP0   = 8'h28;
  localparam logic [7:0]  OFF_CMP1   = 8'h2c;
  // Control word fields
  localparam int          B_ACT      = 0;
  localparam int          B_RUN      = 1;
  localparam int          B_ZERO     = 2;
  localparam int          B_DIV_LO   = 4;
  localparam int          B_DIV_HI   = 6;
  localparam int          B_EN0      = 8;
  localparam int          B_EN1      = 9;
  localparam int          B_SET1     = 16;
  localparam int          B_SET0     = 17;
  localparam int          B_CLR1     = 24;
  localparam int          B_CLR0     = 25;
  localparam logic [31:0] CTRL_USED  = 32'h0303_0377;
  // Values after reset, and the counter's top value
  localparam logic [31:0] CNT_RST    = 32'h0000_0000;
  localparam logic [31:0] CMP_RST    = 32'h0000_0000;
  localparam logic [31:0] CNT_MAX    = 32'hffff_ffff;
  localparam logic [2:0]  DIV_RST    = 3'h0;
  localparam logic [1:0]  EN_RST     = 2'h0;
endpackage

// [verilog/cct_prescaler.sv]
// Purpose: Time-base divider for the free-running counter
// Assumes: sel picks a divide by two to the power sel
// Notes:   Divider restarts whenever counting is halted

`timescale 1ns/1ns

module cct_prescaler (
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  // Control
  input  wire logic                    run,
  input  wire logic [cct_pkg::SEL_W-1:0] sel,
  // Time base
  output logic                         tick
);
  logic [cct_pkg::PRE_W-1:0] div_cnt_ff;
  logic [cct_pkg::PRE_W-1:0] nxt_div_cnt;
  logic [cct_pkg::PRE_W-1:0] mask;

  // ******************************************
  // Divider
  // ******************************************
  always_comb begin
    mask        = cct_pkg::PRE_W'((8'h1 << sel) - 8'h1);
    tick        = run && ((div_cnt_ff & mask) == mask);
    nxt_div_cnt = run ? div_cnt_ff + 7'h1 : 7'h0;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_cnt_ff <= 7'h0;
    end else begin
      div_cnt_ff <= nxt_div_cnt;
    end
  end

  // ******************************************
  // Checks
  // ******************************************
  logic [7:0] gap_ff;
  logic       seen_ff;
  logic [2:0] sel_q_ff;

  always_ff @(posedge sys_clk) begin
    sel_q_ff <= sel;
    if (rst || !run || sel != sel_q_ff) begin
      gap_ff  <= 8'h0;
      seen_ff <= 1'b0;
    end else if (tick) begin
      gap_ff  <= 8'h0;
      seen_ff <= 1'b1;
    end else begin
      gap_ff  <= gap_ff + 8'h1;
    end
  end

  a_div_period: assert property (@(posedge sys_clk) disable iff (rst)
    tick && seen_ff && sel == sel_q_ff |-> gap_ff == (8'h1 << sel) - 8'h1)
    else $error("time base period does not match divider select");
endmodule

// [verilog/cct_match_chan.sv]
// Purpose: One compare channel toggle output and event pulse
// Assumes: hit is already qualified by enable and counter step
// Notes:   Software force beats a match toggle in the same cycle

`timescale 1ns/1ns

module cct_match_chan (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Requests
  input  wire logic hit,
  input  wire logic do_set,
  input  wire logic do_clr,
  // Results
  output logic      out_ff,
  output logic      evt_ff
);
  logic nxt_out;

  // ******************************************
  // Toggle flop
  // ******************************************
  always_comb begin
    nxt_out = out_ff;
    if (do_set) begin
      nxt_out = 1'b1;
    end else if (do_clr) begin
      nxt_out = 1'b0;
    end else if (hit) begin
      nxt_out = !out_ff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_ff <= 1'b0;
      evt_ff <= 1'b0;
    end else begin
      out_ff <= nxt_out;
      evt_ff <= hit;
    end
  end

  a_sw_over_hit: assert property (@(posedge sys_clk) disable iff (rst)
    hit && (do_set || do_clr) |=> out_ff == $past(do_set) && evt_ff)
    else $error("software force did not win over match toggle");
endmodule

// [verilog/cct_timer_ctrl.sv]
// Purpose: Control logic of a capture/compare timer with two compare channels
// Assumes: Register port reads answer one cycle after the read strobe
// Notes:   Event outputs are one-cycle pulses for an interrupt aggregator
// Contract
// - Clear bits read output state; writing 1 forces output low.
// - Clear of one output is ignored if the other set bit is written 1.
// - Set bits read output state; writing 1 forces output high.
// - Enabled channel match toggles its output and sends a compare event.
// - Bits 6 to 4 select the counter time-base divider.
// - Codes 0 to 7 divide by 1 up to 128.
// - Zero bit stops and clears the counter, then clears itself.
// - Run bit starts and halts counting without changing the count.
// - Finishing a zero cycle clears the run bit.
// - Counter is writable only while run bit is 0.
// - Activate bit 0 stops the time base, counting and matches; forces, zero and counter writes still act.
// - Counter wrap to zero raises an overflow event.
//
// The implementer's own choice: the address-and-strobe port.

`timescale 1ns/1ns

module cct_timer_ctrl (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata_ff,
  // Compare outputs
  output logic             match_toggle_out_0,
  output logic             match_toggle_out_1,
  // Events to the aggregator
  output logic             match_event_0,
  output logic             match_event_1,
  output logic             overflow_event_ff
);
  // ******************************************
  // Declarations
  // ******************************************
  logic        act_ff;
  logic        run_ff;
  logic        zero_ff;
  logic [2:0]  div_ff;
  logic [1:0]  en_ff;
  logic [31:0] cnt_ff;
  logic [31:0] cmp_ff [cct_pkg::NUM_CH];
  logic        nxt_act;
  logic        nxt_run;
  logic        nxt_zero;
  logic [2:0]  nxt_div;
  logic [1:0]  nxt_en;
  logic [31:0] nxt_cnt;
  logic [31:0] nxt_cmp [cct_pkg::NUM_CH];
  logic        nxt_ovf;
  logic [31:0] nxt_rdata;
  logic        wr_ctrl;
  logic        wr_cnt;
  logic        pre_run;
  logic        tick;
  logic        cnt_step;
  logic [31:0] cnt_inc;
  logic [1:0]  hit;
  logic [1:0]  do_set;
  logic [1:0]  do_clr;
  logic [1:0]  out_st;
  logic [1:0]  evt;

  assign wr_ctrl = reg_wr && reg_addr == cct_pkg::OFF_CTRL;
  assign wr_cnt  = reg_wr && reg_addr == cct_pkg::OFF_COUNT;

  // ******************************************
  // Control register
  // ******************************************
  always_comb begin
    nxt_act  = act_ff;
    nxt_run  = run_ff;
    nxt_zero = zero_ff;
    nxt_div  = div_ff;
    nxt_en   = en_ff;
    if (wr_ctrl) begin
      // Only defined fields are taken; the rest of the word is dropped
      nxt_act = reg_wdata[cct_pkg::B_ACT];
      nxt_run = reg_wdata[cct_pkg::B_RUN];
      nxt_div = reg_wdata[cct_pkg::B_DIV_HI:cct_pkg::B_DIV_LO];
      nxt_en  = {reg_wdata[cct_pkg::B_EN1], reg_wdata[cct_pkg::B_EN0]};
    end
    if (zero_ff) begin
      nxt_run  = 1'b0;
      nxt_zero = 1'b0;
    end
    if (wr_ctrl && reg_wdata[cct_pkg::B_ZERO]) begin
      nxt_zero = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      act_ff  <= 1'b0;
      run_ff  <= 1'b0;
      zero_ff <= 1'b0;
      div_ff  <= cct_pkg::DIV_RST;
      en_ff   <= cct_pkg::EN_RST;
    end else begin
      act_ff  <= nxt_act;
      run_ff  <= nxt_run;
      zero_ff <= nxt_zero;
      div_ff  <= nxt_div;
      en_ff   <= nxt_en;
    end
  end

  // ******************************************
  // Time base and free-running counter
  // ******************************************
  // An inactive block restarts its divider and holds its counter, standing in for gated clocks
  assign pre_run = act_ff && run_ff && !zero_ff;

  cct_prescaler u_pre (
    .sys_clk (sys_clk),
    .rst     (rst),
    .run     (pre_run),
    .sel     (div_ff),
    .tick    (tick)
  );

  assign cnt_step = tick;
  assign cnt_inc  = cnt_ff + 32'h1;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_ovf = 1'b0;
    nxt_cmp = cmp_ff;
    if (zero_ff) begin
      nxt_cnt = cct_pkg::CNT_RST;
    end else if (wr_cnt && !run_ff) begin
      nxt_cnt = reg_wdata;
    end else if (cnt_step) begin
      nxt_cnt = cnt_inc;
      nxt_ovf = cnt_ff == cct_pkg::CNT_MAX;
    end
    if (reg_wr && reg_addr == cct_pkg::OFF_CMP0) begin
      nxt_cmp[0] = reg_wdata;
    end
    if (reg_wr && reg_addr == cct_pkg::OFF_CMP1) begin
      nxt_cmp[1] = reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_ff            <= cct_pkg::CNT_RST;
      overflow_event_ff <= 1'b0;
      cmp_ff[0]         <= cct_pkg::CMP_RST;
      cmp_ff[1]         <= cct_pkg::CMP_RST;
    end else begin
      cnt_ff            <= nxt_cnt;
      overflow_event_ff <= nxt_ovf;
      cmp_ff            <= nxt_cmp;
    end
  end

  // ******************************************
  // Compare channels
  // ******************************************
  // A clear is dropped when the opposite channel's set is written in the same word
  assign do_set[0] = wr_ctrl && reg_wdata[cct_pkg::B_SET0];
  assign do_set[1] = wr_ctrl && reg_wdata[cct_pkg::B_SET1];
  assign do_clr[0] = wr_ctrl && reg_wdata[cct_pkg::B_CLR0]
                     && !reg_wdata[cct_pkg::B_SET1];
  assign do_clr[1] = wr_ctrl && reg_wdata[cct_pkg::B_CLR1]
                     && !reg_wdata[cct_pkg::B_SET0];

  // Match is judged on the value the counter steps to, so one count gives one event
  for (genvar i = 0; i < cct_pkg::NUM_CH; i++) begin : g_ch
    assign hit[i] = en_ff[i] && cnt_step && !zero_ff
                    && cnt_inc == cmp_ff[i];

    cct_match_chan u_ch (
      .sys_clk (sys_clk),
      .rst     (rst),
      .hit     (hit[i]),
      .do_set  (do_set[i]),
      .do_clr  (do_clr[i]),
      .out_ff  (out_st[i]),
      .evt_ff  (evt[i])
    );
  end

  assign match_toggle_out_0 = out_st[0];
  assign match_toggle_out_1 = out_st[1];
  assign match_event_0      = evt[0];
  assign match_event_1      = evt[1];

  // ******************************************
  // Read data
  // ******************************************
  always_comb begin
    nxt_rdata = 32'h0;
    if (reg_rd) begin
      case (reg_addr)
        cct_pkg::OFF_CTRL: begin
          nxt_rdata[cct_pkg::B_ACT]                     = act_ff;
          nxt_rdata[cct_pkg::B_RUN]                     = run_ff;
          nxt_rdata[cct_pkg::B_ZERO]                    = zero_ff;
          nxt_rdata[cct_pkg::B_DIV_HI:cct_pkg::B_DIV_LO] = div_ff;
          nxt_rdata[cct_pkg::B_EN0]                     = en_ff[0];
          nxt_rdata[cct_pkg::B_EN1]                     = en_ff[1];
          nxt_rdata[cct_pkg::B_SET0]                    = out_st[0];
          nxt_rdata[cct_pkg::B_SET1]                    = out_st[1];
          nxt_rdata[cct_pkg::B_CLR0]                    = out_st[0];
          nxt_rdata[cct_pkg::B_CLR1]                    = out_st[1];
        end
        cct_pkg::OFF_COUNT: begin
          nxt_rdata = cnt_ff;
        end
        cct_pkg::OFF_CMP0: begin
          nxt_rdata = cmp_ff[0];
        end
        cct_pkg::OFF_CMP1: begin
          nxt_rdata = cmp_ff[1];
        end
        default: begin
          nxt_rdata = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata_ff <= 32'h0;
    end else begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // ******************************************
  // Checks
  // ******************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_zero_req;
    wr_ctrl && reg_wdata[cct_pkg::B_ZERO];
  endsequence

  sequence s_zero_done;
    zero_ff ##1 (cnt_ff == cct_pkg::CNT_RST && !run_ff);
  endsequence

  a_zero_cycle: assert property (s_zero_req |=> s_zero_done)
    else $error("zero request did not clear counter and run bit");

  a_clr_forces: assert property (do_clr[0] && !do_set[0] |=> !match_toggle_out_0)
    else $error("clear did not force output low");

  a_clr_blocked: assert property (wr_ctrl && reg_wdata[cct_pkg::B_CLR0]
    && reg_wdata[cct_pkg::B_SET1] && !hit[0] && !do_set[0]
    |=> match_toggle_out_0 == $past(match_toggle_out_0))
    else $error("blocked clear changed output");

  a_set_forces: assert property (do_set[1] ##1 reg_rd && reg_addr == cct_pkg::OFF_CTRL
    |=> reg_rdata_ff[cct_pkg::B_SET1] && reg_rdata_ff[cct_pkg::B_CLR1])
    else $error("set output not seen in read back");

  a_match_toggle: assert property (hit[0] && !do_set[0] && !do_clr[0]
    |=> match_toggle_out_0 != $past(match_toggle_out_0) && match_event_0)
    else $error("match did not toggle and signal");

  a_no_match_off: assert property (!en_ff[1] |=> !match_event_1)
    else $error("disabled channel raised event");

  a_count_hold: assert property (!cnt_step && !zero_ff && !wr_cnt |=> $stable(cnt_ff))
    else $error("counter moved without a step");

  a_wrap_event: assert property (cnt_step && !zero_ff && cnt_ff == cct_pkg::CNT_MAX
    |=> cnt_ff == cct_pkg::CNT_RST && overflow_event_ff)
    else $error("counter wrap not flagged");

  a_cnt_ro: assert property (wr_cnt && run_ff && !zero_ff && !cnt_step
    |=> cnt_ff == $past(cnt_ff))
    else $error("counter written while running");

  a_gate_off: assert property (!act_ff |-> !tick && hit == 2'b00)
    else $error("inactive block still counting");

  a_resv_zero: assert property (reg_rd && reg_addr == cct_pkg::OFF_CTRL
    |=> (reg_rdata_ff & ~cct_pkg::CTRL_USED) == 32'h0)
    else $error("reserved control bits read nonzero");

  // ******************************************
  // Checks: read back, channel rules, counter, divider, zero and overflow
  // ******************************************
  // Read back shows the state held in the strobe cycle, not the one after it
  sequence s_ctrl_read;
    reg_rd && reg_addr == cct_pkg::OFF_CTRL;
  endsequence

  a_act_readback: assert property (s_ctrl_read
    |=> reg_rdata_ff[cct_pkg::B_ACT] == $past(act_ff))
    else $error("activate bit read back wrong");

  a_run_readback: assert property (s_ctrl_read
    |=> reg_rdata_ff[cct_pkg::B_RUN] == $past(run_ff))
    else $error("run bit read back wrong");

  a_div_readback: assert property (s_ctrl_read
    |=> reg_rdata_ff[cct_pkg::B_DIV_HI:cct_pkg::B_DIV_LO] == $past(div_ff))
    else $error("divider select read back wrong");

  a_en_readback: assert property (s_ctrl_read
    |=> reg_rdata_ff[cct_pkg::B_EN1:cct_pkg::B_EN0] == $past(en_ff))
    else $error("channel enables read back wrong");

  a_set0_forces: assert property (do_set[0]
    |=> match_toggle_out_0)
    else $error("set did not force output high");

  a_clr1_forces: assert property (do_clr[1] && !do_set[1]
    |=> !match_toggle_out_1)
    else $error("clear did not force output low");

  a_clr1_blocked: assert property (wr_ctrl && reg_wdata[cct_pkg::B_CLR1]
    && reg_wdata[cct_pkg::B_SET0] && !hit[1] && !do_set[1]
    |=> match_toggle_out_1 == $past(match_toggle_out_1))
    else $error("blocked clear changed output");

  a_hit1_event: assert property (hit[1]
    |=> match_event_1)
    else $error("match did not send an event");

  a_cnt_write: assert property (wr_cnt && !run_ff && !zero_ff
    |=> cnt_ff == $past(reg_wdata))
    else $error("stopped counter did not take the write");

  a_div1_tick: assert property (act_ff && run_ff && !zero_ff
    && div_ff == 3'h0 |-> tick)
    else $error("divide by one missed a step");

  a_zero_self: assert property (zero_ff && !(wr_ctrl && reg_wdata[cct_pkg::B_ZERO])
    |=> !zero_ff)
    else $error("zero bit did not clear itself");

  a_ovf_at_zero: assert property (overflow_event_ff
    |-> cnt_ff == cct_pkg::CNT_RST)
    else $error("overflow flagged away from a wrap");
endmodule

// [testbench/cct_irq_agg_model.sv]
// Purpose: Interrupt aggregator stand-in that tallies event pulses
// Assumes: Events are one-cycle pulses on sys_clk
// Notes:   Tallies wrap at 8 bits; the bench takes differences only

`timescale 1ns/1ns

module cct_irq_agg_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Events from the timer
  input  wire logic       evt_m0,
  input  wire logic       evt_m1,
  input  wire logic       evt_ovf,
  // Tallies
  output logic      [7:0] n_m0,
  output logic      [7:0] n_m1,
  output logic      [7:0] n_ovf
);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      n_m0  <= 8'h00;
      n_m1  <= 8'h00;
      n_ovf <= 8'h00;
    end else begin
      n_m0  <= n_m0 + {7'h00, evt_m0};
      n_m1  <= n_m1 + {7'h00, evt_m1};
      n_ovf <= n_ovf + {7'h00, evt_ovf};
    end
  end
endmodule

// [testbench/testbench.sv]
// Purpose: Self-checking bench for the timer control block
// Assumes: Reads answer one cycle after the strobe; div code 0 steps every cycle
// Notes:   Run windows are counted in edges between the two control writes

`timescale 1ns/1ns

module testbench;
  logic        sys_clk;
  logic        rst;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata_ff;
  logic        out0;
  logic        out1;
  logic        ev0;
  logic        ev1;
  logic        ovf;
  logic [7:0]  n_m0;
  logic [7:0]  n_m1;
  logic [7:0]  n_ovf;
  logic [31:0] rd_val;
  int          num_errors;
  int          n_tests;

  cct_timer_ctrl u_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .match_toggle_out_0(out0), .match_toggle_out_1(out1), .match_event_0(ev0),
    .match_event_1(ev1), .overflow_event_ff(ovf));

  cct_irq_agg_model u_agg (.sys_clk(sys_clk), .rst(rst), .evt_m0(ev0), .evt_m1(ev1),
    .evt_ovf(ovf), .n_m0(n_m0), .n_m1(n_m1), .n_ovf(n_ovf));

  always #4 sys_clk = ~sys_clk;

  // ******************************************
  // Bus and compare tasks
  // ******************************************
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic timeout(input string nm);
    num_errors++;
    $display("no response in %s", nm);
    summarize;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic wc(input logic [31:0] d);
    wr(cct_pkg::OFF_CTRL, d);
  endtask

  // Read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    rd_val = reg_rdata_ff;
  endtask

  // Write then read with no idle cycle; the address stays put across both strobes
  task automatic wrrd(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge sys_clk);
    reg_rd    <= 1'b0;
    #1;
    rd_val = reg_rdata_ff;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_val, exp);
  endtask

  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask

  // ******************************************
  // Scenarios
  // ******************************************
  task automatic t_reset;
    rdchk(cct_pkg::OFF_CTRL, 32'h0000_0000);
    rdchk(cct_pkg::OFF_COUNT, cct_pkg::CNT_RST);
    rdchk(cct_pkg::OFF_CMP1, cct_pkg::CMP_RST);
    chk({29'h0, out0, out1, ovf}, 32'h0000_0000);
    wc(~cct_pkg::CTRL_USED);
    rdchk(cct_pkg::OFF_CTRL, 32'h0000_0000);
    wr(8'h04, 32'hffff_ffff);
    rdchk(8'h04, 32'h0000_0000);
    done("reset");
  endtask

  task automatic t_force;
    wc(32'h0002_0000);
    rdchk(cct_pkg::OFF_CTRL, 32'h0202_0000);
    wrrd(cct_pkg::OFF_CTRL, 32'h0201_0000);
    chk(rd_val, 32'h0303_0000);
    wc(32'h0102_0000);
    rdchk(cct_pkg::OFF_CTRL, 32'h0303_0000);
    wc(32'h0300_0000);
    rdchk(cct_pkg::OFF_CTRL, 32'h0000_0000);
    chk({30'h0, out1, out0}, 32'h0000_0000);
    done("force");
  endtask

  // Every code runs eight of its own ticks; codes 1 to 7 get one spare edge to absorb divider phase
  task automatic t_divider;
    for (int k = 0; k < 8; k++) begin
      wr(cct_pkg::OFF_COUNT, 32'h0000_0000);
      wc({25'h0, 3'(k), 4'h3});
      repeat ((8 << k) - 2 + ((k > 0) ? 1 : 0)) @(posedge sys_clk);
      wc({25'h0, 3'(k), 4'h1});
      rdchk(cct_pkg::OFF_COUNT, 32'h0000_0008);
    end
    done("divider");
  endtask

  task automatic t_run;
    wr(cct_pkg::OFF_COUNT, 32'h0000_0010);
    rdchk(cct_pkg::OFF_COUNT, 32'h0000_0010);
    wc(32'h0000_0003);
    wr(cct_pkg::OFF_COUNT, 32'h0000_5555);
    wc(32'h0000_0001);
    rdchk(cct_pkg::OFF_COUNT, 32'h0000_0014);
    rdchk(cct_pkg::OFF_COUNT, 32'h0000_0014);
    wc(32'h0000_0002);
    repeat (8) @(posedge sys_clk);
    wc(32'h0000_0001);
    rdchk(cct_pkg::OFF_COUNT, 32'h0000_0014);
    done("run");
  endtask

  task automatic t_zero;
    int i;
    wc(32'h0000_0003);
    repeat (5) @(posedge sys_clk);
    wc(32'h0000_0007);
    for (i = 0; i < 10; i++) begin
      rd(cct_pkg::OFF_CTRL);
      if (rd_val[2] === 1'b0) break;
    end
    if (i == 10) timeout("zero");
    chk(rd_val, 32'h0000_0001);
    rdchk(cct_pkg::OFF_COUNT, 32'h0000_0000);
    done("zero");
  endtask

  task automatic t_wrap;
    logic [7:0] b;
    b = n_ovf;
    wr(cct_pkg::OFF_COUNT, 32'hffff_fffd);
    wc(32'h0000_0003);
    repeat (2) @(posedge sys_clk);
    wc(32'h0000_0001);
    rdchk(cct_pkg::OFF_COUNT, 32'h0000_0001);
    chk({24'h0, n_ovf - b}, 32'h0000_0001);
    done("wrap");
  endtask

  task automatic t_match;
    logic [7:0] b0;
    logic [7:0] b1;
    int         i;
    b0 = n_m0;
    b1 = n_m1;
    wr(cct_pkg::OFF_COUNT, 32'h0000_0010);
    wr(cct_pkg::OFF_CMP0, 32'h0000_0018);
    wr(cct_pkg::OFF_CMP1, 32'h0000_0018);
    wc(32'h0000_0103);
    for (i = 0; i < 40 && ev0 !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (i == 40) timeout("match");
    wc(32'h0000_0101);
    rdchk(cct_pkg::OFF_CTRL, 32'h0202_0101);
    chk({24'h0, n_m0 - b0}, 32'h0000_0001);
    chk({24'h0, n_m1 - b1}, 32'h0000_0000);
    wc(32'h0000_0001);
    wc(32'h0200_0001);
    #1;
    chk({30'h0, out1, out0}, 32'h0000_0000);
    done("match");
  endtask

  // Clear of output 1 lands on the very edge at which channel 1 matches
  task automatic t_sw;
    logic [7:0] b;
    b = n_m1;
    wr(cct_pkg::OFF_COUNT, 32'h0000_0100);
    wr(cct_pkg::OFF_CMP1, 32'h0000_0108);
    wc(32'h0000_0203);
    repeat (6) @(posedge sys_clk);
    wc(32'h0100_0203);
    wc(32'h0000_0001);
    chk({31'h0, out1}, 32'h0000_0000);
    chk({24'h0, n_m1 - b}, 32'h0000_0001);
    rdchk(cct_pkg::OFF_COUNT, 32'h0000_010a);
    done("sw");
  endtask

  initial begin
    sys_clk    = 1'b0;
    rst        = 1'b1;
    reg_addr   = 8'h00;
    reg_wdata  = 32'h0000_0000;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    num_errors = 0;
    n_tests    = 0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset;
    t_force;
    t_divider;
    t_run;
    t_zero;
    t_wrap;
    t_match;
    t_sw;
    summarize;
  end
endmodule
